// File: rtl/wpr_packet_receiver.sv
// Backchannel bit, byte and packet decoder of the wireless power receiver
// Notes on behaviour
// - preamble of 11 to 25 ONE bits; the first ZERO is the start bit.
// - mid-bit transition decodes ONE; none within the bit decodes ZERO.
// - half-bit spacing 200-300 us, full-bit 400-600 us, else a bit error.
// - a transition at neither point rejects the bit and restarts preamble hunting.
// - each byte is one fixed 11-bit asynchronous frame.
// - decoded bits shift into an assembly register with a running bit count.
// - after 11 bits even parity is checked; only passing frames are bytes.
// - a parity failure abandons the packet and restarts preamble hunting.
// - the first byte is the header; it alone sets the message length.
// - length is fixed at header acceptance; bytes collect until it is reached.
// - after the last byte the checksum is computed and compared.
// - matching packets are released; mismatching ones are discarded entirely.
// - timeout clears bit count, byte buffer, byte index, length and checksum; pkt_buf keeps its bytes.
`timescale 1ns/100ps
`include "wpr_params.svh"
module wpr_packet_receiver
  import wpr_pkg::*;
#(
  parameter logic [`WPR_CNT_W-1:0] HALF_MIN_CYC = `WPR_CNT_W'(`WPR_HALF_MIN_US * `WPR_CLK_MHZ),
  parameter logic [`WPR_CNT_W-1:0] HALF_MAX_CYC = `WPR_CNT_W'(`WPR_HALF_MAX_US * `WPR_CLK_MHZ),
  parameter logic [`WPR_CNT_W-1:0] FULL_MIN_CYC = `WPR_CNT_W'(`WPR_FULL_MIN_US * `WPR_CLK_MHZ),
  parameter logic [`WPR_CNT_W-1:0] FULL_MAX_CYC = `WPR_CNT_W'(`WPR_FULL_MAX_US * `WPR_CLK_MHZ),
  parameter logic [`WPR_CNT_W-1:0] TIMEOUT_CYC = `WPR_CNT_W'(`WPR_TIMEOUT_US * `WPR_CLK_MHZ),
  parameter logic [`WPR_ONES_W-1:0] PRE_MIN = `WPR_ONES_W'(`WPR_PRE_MIN),
  parameter logic [`WPR_ONES_W-1:0] PRE_MAX = `WPR_ONES_W'(`WPR_PRE_MAX)
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic comm_in,
  output wpr_pkt_t rx_pkt,
  output logic chk_fail,
  output logic byte_err
);

  wpr_edge_t edge_info;
  wpr_state_t state;
  logic half_pend;
  logic next_half_pend;
  logic [`WPR_ONES_W-1:0] ones_cnt;
  logic [`WPR_BIT_CNT_W-1:0] bit_cnt;
  logic [`WPR_FRAME_BITS-1:0] shreg;
  logic [`WPR_IDX_W-1:0] byte_idx;
  logic [`WPR_IDX_W-1:0] exp_last;
  logic [7:0] chk_acc;
  logic [7:0] pkt_buf [`WPR_MAX_BYTES];
  logic rel_active;
  logic [`WPR_IDX_W-1:0] rel_idx;
  logic [`WPR_IDX_W-1:0] rel_last;

  logic is_half;
  logic is_full;
  logic bit_ok;
  logic bit_val;
  logic bit_err;
  logic [`WPR_FRAME_BITS-1:0] frame_word;
  logic [7:0] rx_byte;
  logic byte_done;
  logic byte_good;
  logic pkt_end;
  logic chk_match;
  logic preamble_done;
  logic abort;

  wpr_edge_timer #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_edge_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .comm_in(comm_in),
    .edge_info(edge_info)
  );

  function automatic logic in_window(
    input logic [`WPR_CNT_W-1:0] iv,
    input logic [`WPR_CNT_W-1:0] lo,
    input logic [`WPR_CNT_W-1:0] hi
  );
    in_window = (iv >= lo) && (iv <= hi);
  endfunction : in_window

  assign is_half = in_window(edge_info.interval, HALF_MIN_CYC, HALF_MAX_CYC);
  assign is_full = in_window(edge_info.interval, FULL_MIN_CYC, FULL_MAX_CYC);

  // Bit decode from edge spacing
  always_comb
  begin
    bit_ok = 1'b0;
    bit_val = 1'b0;
    bit_err = 1'b0;
    next_half_pend = half_pend;
    if (edge_info.edge_seen)
    begin
      if (is_half)
      begin
        if (half_pend)
        begin
          bit_ok = 1'b1;
          bit_val = 1'b1;
          next_half_pend = 1'b0;
        end
        else
          next_half_pend = 1'b1;
      end
      else if (is_full)
      begin
        next_half_pend = 1'b0;
        // Hunting resyncs the half-bit phase on a full interval
        if (half_pend && state == wpr_st_frame)
          bit_err = 1'b1;
        else
          bit_ok = 1'b1;
      end
      else
      begin
        bit_err = 1'b1;
        next_half_pend = 1'b0;
      end
    end
  end

  assign frame_word = {bit_val, shreg[`WPR_FRAME_BITS-1:1]};
  assign rx_byte = frame_word[`WPR_POS_DATA_MSB:`WPR_POS_DATA_LSB];
  assign byte_done = (state == wpr_st_frame) && bit_ok
                     && (bit_cnt == `WPR_FRAME_BITS - `WPR_BIT_CNT_W'(1));
  assign byte_good = !frame_word[`WPR_POS_START] && frame_word[`WPR_POS_STOP]
                     && !(^frame_word[`WPR_POS_PARITY:`WPR_POS_DATA_LSB]);
  assign chk_match = (chk_acc == rx_byte);
  assign pkt_end = byte_done && byte_good && (byte_idx != '0) && (byte_idx == exp_last);
  assign preamble_done = (state == wpr_st_hunt) && bit_ok && !bit_val
                         && (ones_cnt >= PRE_MIN) && (ones_cnt <= PRE_MAX);
  assign abort = edge_info.timeout
                 || ((state == wpr_st_frame) && (bit_err || (byte_done && !byte_good)));

  always_ff @(posedge ref_clk)
  begin
    if (srst || abort || pkt_end)
      state <= wpr_st_hunt;
    else if (preamble_done)
      state <= wpr_st_frame;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || edge_info.timeout)
      half_pend <= 1'b0;
    else
      half_pend <= next_half_pend;
  end

  // Preamble ONE counter, saturating one past the maximum
  always_ff @(posedge ref_clk)
  begin
    if (srst || edge_info.timeout || state != wpr_st_hunt || bit_err)
      ones_cnt <= '0;
    else if (bit_ok && bit_val)
    begin
      if (ones_cnt <= PRE_MAX)
        ones_cnt <= ones_cnt + `WPR_ONES_W'(1);
    end
    else if (bit_ok)
      ones_cnt <= '0;
  end

  // Frame assembly, LSB first into the top of the shifter
  always_ff @(posedge ref_clk)
  begin
    if (srst || abort || (state == wpr_st_hunt && !preamble_done))
    begin
      bit_cnt <= '0;
      shreg <= '0;
    end
    else if (preamble_done)
    begin
      bit_cnt <= `WPR_BIT_CNT_W'(1);
      shreg <= '0;
    end
    else if (byte_done)
      bit_cnt <= '0;
    else if (bit_ok)
    begin
      shreg <= frame_word;
      bit_cnt <= bit_cnt + `WPR_BIT_CNT_W'(1);
    end
  end

  // Packet length and checksum accumulation
  always_ff @(posedge ref_clk)
  begin
    if (srst || abort || pkt_end || state == wpr_st_hunt)
    begin
      byte_idx <= '0;
      exp_last <= '0;
      chk_acc <= 8'h00;
    end
    else if (byte_done && byte_good)
    begin
      byte_idx <= byte_idx + `WPR_IDX_W'(1);
      chk_acc <= chk_acc ^ rx_byte;
      if (byte_idx == '0)
        exp_last <= wpr_msg_len(rx_byte) + `WPR_IDX_W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (byte_done && byte_good && !pkt_end)
      pkt_buf[byte_idx] <= rx_byte;
  end

  // Release sequencer for checked packets
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rel_active <= 1'b0;
      rel_idx <= '0;
      rel_last <= '0;
    end
    else if (pkt_end && chk_match)
    begin
      rel_active <= 1'b1;
      rel_idx <= '0;
      rel_last <= byte_idx - `WPR_IDX_W'(1);
    end
    else if (rel_active)
    begin
      rel_idx <= rel_idx + `WPR_IDX_W'(1);
      if (rel_idx == rel_last)
        rel_active <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rx_pkt <= '0;
    else
    begin
      rx_pkt.valid <= rel_active;
      rx_pkt.first <= rel_active && (rel_idx == '0);
      rx_pkt.last <= rel_active && (rel_idx == rel_last);
      rx_pkt.data <= rel_active ? pkt_buf[rel_idx] : 8'h00;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      chk_fail <= 1'b0;
      byte_err <= 1'b0;
    end
    else
    begin
      chk_fail <= pkt_end && !chk_match;
      byte_err <= byte_done && !byte_good && !edge_info.timeout;
    end
  end
endmodule : wpr_packet_receiver

// File: rtl/wpr_params.svh
// Constants for the wireless power packet receiver
`ifndef WPR_PARAMS_SVH
`define WPR_PARAMS_SVH

`define WPR_CLK_MHZ 250
`define WPR_HALF_MIN_US 200
`define WPR_HALF_MAX_US 300
`define WPR_FULL_MIN_US 400
`define WPR_FULL_MAX_US 600
`define WPR_TIMEOUT_US 800
`define WPR_CNT_W 18
`define WPR_CNT_MAX 18'h3FFFF

`define WPR_PRE_MIN 11
`define WPR_PRE_MAX 25
`define WPR_ONES_W 5

`define WPR_FRAME_BITS 4'hB
`define WPR_BIT_CNT_W 4
`define WPR_POS_START 0
`define WPR_POS_DATA_LSB 1
`define WPR_POS_DATA_MSB 8
`define WPR_POS_PARITY 9
`define WPR_POS_STOP 10

`define WPR_MAX_BYTES 29
`define WPR_IDX_W 5

`define WPR_HDR_BAND1 8'h20
`define WPR_HDR_BAND2 8'h80
`define WPR_HDR_BAND3 8'hE0
`define WPR_LEN_BASE0 5'h01
`define WPR_LEN_BASE1 5'h02
`define WPR_LEN_BASE2 5'h08
`define WPR_LEN_BASE3 5'h14
`define WPR_LEN_SHIFT1 4
`define WPR_LEN_SHIFT2 3
`define WPR_LEN_SHIFT3 2

`endif

// File: rtl/wpr_pkg.sv
// Types and shared functions of the wireless power packet receiver
package wpr_pkg;
  `include "wpr_params.svh"

  typedef struct packed {
    logic edge_seen;
    logic timeout;
    logic [`WPR_CNT_W-1:0] interval;
  } wpr_edge_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } wpr_pkt_t;

  typedef enum logic {
    wpr_st_hunt,
    wpr_st_frame
  } wpr_state_t;

  // Message byte count implied by the header
  function automatic logic [`WPR_IDX_W-1:0] wpr_msg_len(input logic [7:0] hdr);
    logic [7:0] off;
    off = 8'h00;
    if (hdr < `WPR_HDR_BAND1)
    begin
      wpr_msg_len = `WPR_LEN_BASE0;
    end
    else if (hdr < `WPR_HDR_BAND2)
    begin
      off = (hdr - `WPR_HDR_BAND1) >> `WPR_LEN_SHIFT1;
      wpr_msg_len = `WPR_LEN_BASE1 + off[`WPR_IDX_W-1:0];
    end
    else if (hdr < `WPR_HDR_BAND3)
    begin
      off = (hdr - `WPR_HDR_BAND2) >> `WPR_LEN_SHIFT2;
      wpr_msg_len = `WPR_LEN_BASE2 + off[`WPR_IDX_W-1:0];
    end
    else
    begin
      off = (hdr - `WPR_HDR_BAND3) >> `WPR_LEN_SHIFT3;
      wpr_msg_len = `WPR_LEN_BASE3 + off[`WPR_IDX_W-1:0];
    end
  endfunction : wpr_msg_len
endpackage : wpr_pkg

// File: rtl/wpr_edge_timer.sv
// Input synchroniser and edge interval timer
`timescale 1ns/100ps
`include "wpr_params.svh"
module wpr_edge_timer
  import wpr_pkg::*;
#(
  parameter logic [`WPR_CNT_W-1:0] TIMEOUT_CYC = `WPR_CNT_W'(`WPR_TIMEOUT_US * `WPR_CLK_MHZ)
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic comm_in,
  output wpr_edge_t edge_info
);

  logic [2:0] sync_q;
  logic stable_lvl;
  logic [`WPR_CNT_W-1:0] edge_interval_timer;
  logic edge_now;

  // Change counts once second and third stage agree
  assign edge_now = (sync_q[1] == sync_q[2]) && (sync_q[2] != stable_lvl);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], comm_in};
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      stable_lvl <= 1'b0;
    else if (edge_now)
      stable_lvl <= sync_q[2];
  end

  // Counts cycles since last edge, saturating
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      edge_interval_timer <= `WPR_CNT_MAX;
    else if (edge_now)
      edge_interval_timer <= `WPR_CNT_W'(1);
    else if (edge_interval_timer != `WPR_CNT_MAX)
      edge_interval_timer <= edge_interval_timer + `WPR_CNT_W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      edge_info <= '0;
    else
    begin
      edge_info.edge_seen <= edge_now;
      edge_info.interval <= edge_interval_timer;
      edge_info.timeout <= !edge_now && (edge_interval_timer == TIMEOUT_CYC);
    end
  end
endmodule : wpr_edge_timer

// File: test/wpr_packet_receiver_chk.sv
// Port assertions of the packet receiver
`timescale 1ns/100ps
module wpr_packet_receiver_chk
  import wpr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic comm_in,
  input wpr_pkt_t rx_pkt,
  input wire logic chk_fail,
  input wire logic byte_err
);
  logic prev;
  logic [7:0] quiet;
  // Cycles since the line last moved
  always_ff @(posedge ref_clk)
  begin
    prev <= comm_in;
    if (srst || comm_in != prev)
      quiet <= 8'h00;
    else if (quiet != 8'hFF)
      quiet <= quiet + 8'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_more;
    rx_pkt.valid && !rx_pkt.last;
  endsequence
  sequence s_next;
    rx_pkt.valid && !rx_pkt.first;
  endsequence
  a_burst_run: assert property (s_more |=> s_next) else $error("release burst broken");
  a_burst_head: assert property ($rose(rx_pkt.valid) |-> rx_pkt.first) else $error("burst without header");
  a_burst_end: assert property (rx_pkt.last |=> !rx_pkt.valid) else $error("release after last");
  a_idle_data: assert property (!rx_pkt.valid |-> rx_pkt.data == 8'h00) else $error("data while idle");
  a_flag_qual: assert property ((rx_pkt.first || rx_pkt.last) |-> rx_pkt.valid) else $error("flag without valid");
  a_fail_excl: assert property (chk_fail |-> !rx_pkt.valid ##1 !chk_fail) else $error("failed packet released");
  a_err_drop: assert property (byte_err |=> (!rx_pkt.valid && !chk_fail && !byte_err) [*8])
    else $error("output after byte error");
  a_quiet_out: assert property (quiet >= 8'h50 |-> !rx_pkt.valid && !chk_fail) else $error("output on silent line");
endmodule : wpr_packet_receiver_chk
bind wpr_packet_receiver wpr_packet_receiver_chk u_chk (.ref_clk(ref_clk), .srst(srst), .comm_in(comm_in),
  .rx_pkt(rx_pkt), .chk_fail(chk_fail), .byte_err(byte_err));

// File: test/wpr_sender.sv
// Backchannel sender model driving biphase bits onto the receiver input
`timescale 1ns/100ps
module wpr_sender
(
  input wire logic ref_clk,
  output logic line
);
  initial line = 1'b0;
  task automatic tog(input int n);
    repeat (n) @(posedge ref_clk);
    #1 line = ~line;
  endtask : tog
  task automatic send_bit(input logic v);
    if (v)
    begin
      tog(25);
      tog(25);
    end
    else
      tog(50);
  endtask : send_bit
  task automatic send_pkt(input int pre, input logic [7:0] b [$], input int perr, input int cut, input int gl);
    logic [10:0] fr;
    tog(1);
    repeat (pre) send_bit(1'b1);
    foreach (b[i])
    begin
      if (i == cut)
      begin
        if (gl != 0)
          tog(35);
        return;
      end
      fr = {1'b1, (^b[i]) ^ (i == perr), b[i], 1'b0};
      for (int k = 0; k < 11; k++)
        send_bit(fr[k]);
    end
  endtask : send_pkt
endmodule : wpr_sender

// File: test/test_wpr_packet_receiver.sv
// Self-checking bench of the packet receiver
`timescale 1ns/100ps
module test_wpr_packet_receiver
  import wpr_pkg::*;
;
  typedef logic [7:0] wpr_bytes_t [$];
  logic ref_clk;
  logic srst;
  logic comm_in;
  wpr_pkt_t rx_pkt;
  logic chk_fail;
  logic byte_err;
  int miscompares;
  int compares;
  int nfail;
  int nerr;
  logic [9:0] got [$];
  wpr_packet_receiver #(.HALF_MIN_CYC(18'h00014), .HALF_MAX_CYC(18'h0001E), .FULL_MIN_CYC(18'h00028),
    .FULL_MAX_CYC(18'h0003C), .TIMEOUT_CYC(18'h00050)) u_dut (.ref_clk(ref_clk), .srst(srst),
    .comm_in(comm_in), .rx_pkt(rx_pkt), .chk_fail(chk_fail), .byte_err(byte_err));
  wpr_sender u_snd (.ref_clk(ref_clk), .line(comm_in));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (rx_pkt.valid === 1'b1)
      got.push_back({rx_pkt.first, rx_pkt.last, rx_pkt.data});
    if (chk_fail === 1'b1)
      nfail++;
    if (byte_err === 1'b1)
      nerr++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic wpr_bytes_t mkpkt(input logic [7:0] hdr, input int n);
    wpr_bytes_t q;
    logic [7:0] s;
    q = {hdr};
    s = hdr;
    for (int i = 1; i <= n; i++)
    begin
      q.push_back(hdr + 8'(i * 8'h35));
      s = s ^ q[i];
    end
    q.push_back(s);
    return q;
  endfunction : mkpkt
  task automatic xfer(input int pre, input wpr_bytes_t b, input int perr, input int cut, input int gl);
    got.delete();
    nfail = 0;
    nerr = 0;
    u_snd.send_pkt(pre, b, perr, cut, gl);
    repeat (150) @(posedge ref_clk);
    #1;
  endtask : xfer
  task automatic expect_out(input wpr_bytes_t b, input int n, input int f, input int e);
    chk(got.size(), n);
    for (int i = 0; i < n && i < got.size(); i++)
      chk(got[i], {i == 0, i == n - 1, b[i]});
    chk(nfail, f);
    chk(nerr, e);
  endtask : expect_out
  task automatic t_lengths;
    logic [7:0] hdr [4];
    int len [4];
    wpr_bytes_t b;
    hdr = '{8'h1F, 8'h20, 8'h80, 8'hE0};
    len = '{1, 2, 8, 20};
    foreach (hdr[i])
    begin
      b = mkpkt(hdr[i], len[i]);
      xfer(11, b, -1, -1, 0);
      expect_out(b, len[i] + 1, 0, 0);
    end
    $display("test lengths done");
  endtask : t_lengths
  task automatic t_preamble;
    wpr_bytes_t b;
    b = mkpkt(8'h05, 1);
    xfer(10, b, -1, -1, 0);
    expect_out(b, 0, 0, 0);
    xfer(26, b, -1, -1, 0);
    expect_out(b, 0, 0, 0);
    xfer(25, b, -1, -1, 0);
    expect_out(b, 2, 0, 0);
    $display("test preamble done");
  endtask : t_preamble
  task automatic t_bad_sum;
    wpr_bytes_t b;
    b = mkpkt(8'h30, 3);
    b[4] = b[4] ^ 8'h01;
    xfer(12, b, -1, -1, 0);
    expect_out(b, 0, 1, 0);
    $display("test checksum done");
  endtask : t_bad_sum
  task automatic t_parity;
    wpr_bytes_t b;
    b = mkpkt(8'h10, 1);
    xfer(12, b, 1, -1, 0);
    expect_out(b, 0, 0, 1);
    $display("test parity done");
  endtask : t_parity
  task automatic t_abort;
    wpr_bytes_t b;
    b = mkpkt(8'h10, 1);
    xfer(12, b, -1, 1, 1);
    expect_out(b, 0, 0, 0);
    xfer(12, b, -1, 2, 0);
    expect_out(b, 0, 0, 0);
    b = mkpkt(8'h40, 4);
    xfer(12, b, -1, -1, 0);
    expect_out(b, 5, 0, 0);
    $display("test abort done");
  endtask : t_abort
  task automatic t_reset;
    wpr_bytes_t b;
    b = mkpkt(8'h10, 1);
    got.delete();
    nfail = 0;
    nerr = 0;
    // Reset lands in the middle of the header frame
    fork
      u_snd.send_pkt(12, b, -1, -1, 0);
      begin
        repeat (800) @(posedge ref_clk);
        #1 srst = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1 srst = 1'b0;
      end
    join
    repeat (150) @(posedge ref_clk);
    #1;
    expect_out(b, 0, 0, 0);
    xfer(12, b, -1, -1, 0);
    expect_out(b, 2, 0, 0);
    $display("test reset done");
  endtask : t_reset
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    miscompares = 0;
    compares = 0;
    srst = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    t_lengths();
    t_preamble();
    t_bad_sum();
    t_parity();
    t_abort();
    t_reset();
    final_report();
  end
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    final_report();
  end
endmodule : test_wpr_packet_receiver
